/* core/sgc_top.sv */
// Switchgear command arbitration and trip manager.
// Assumes one 10 MHz clock, synchronous inputs, classic Wishbone master.
`timescale 1ns/10ps
`include "sgc_consts.svh"
`default_nettype none

module sgc_top #(
	parameter int NSRC       = 8,
	parameter int PULSE_CYC  = 1000,
	parameter int HOLD_W     = 32
) (
	// Clock and reset
	input  wire logic              clk_i,
	input  wire logic              rst_i,
	// Wishbone slave
	input  wire logic              wb_cyc_i,
	input  wire logic              wb_stb_i,
	input  wire logic              wb_we_i,
	input  wire logic [7:0]        wb_adr_i,
	input  wire logic [3:0]        wb_sel_i,
	input  wire logic [31:0]       wb_dat_i,
	output logic      [31:0]       wb_dat_o,
	output logic                   wb_ack_o,
	// Command sources
	input  wire logic              panel_close_i,
	input  wire logic              panel_open_i,
	input  wire logic              remote_close_i,
	input  wire logic              remote_open_i,
	input  wire logic              ext_close_source_i,
	input  wire logic              ext_open_source_i,
	input  wire logic              int_close_i,
	input  wire logic              int_open_i,
	input  wire logic              auto_reclose_unit_i,
	// Protection
	input  wire logic [NSRC-1:0]   prot_trip_i,
	input  wire logic              prot_block_i,
	input  wire logic              trip_ack_source_i,
	// Interlocks and release
	input  wire logic [2:0]        ilock_close_i,
	input  wire logic [2:0]        ilock_open_i,
	input  wire logic              sync_release_i,
	input  wire logic              bypass_sig_i,
	// Breaker position
	input  wire logic [1:0]        aux_pos_i,
	// Breaker coils and display
	output logic                   close_coil_o,
	output logic                   trip_coil_o,
	output logic [1:0]             pos_o,
	output logic                   override_flag_o,
	output logic                   busy_o
);

	// ==========================================================
	// Registers
	logic [8:0]          ctrl_q;        // Control fields
	logic [NSRC-1:0]     asgn_q;        // Trip source assignment
	logic [HOLD_W-1:0]   hold_q;        // Minimum trip hold, cycles
	logic [31:0]         synclim_q;     // Sync wait limit, cycles
	logic [31:0]         byptime_q;     // Bypass time, cycles
	logic                sw_close_q;    // Software close pulse
	logic                sw_open_q;     // Software open pulse
	logic                sw_ack_q;      // Software ack pulse
	logic                sw_byp_q;      // Software bypass start

	// Field views
	logic [1:0] auth;
	logic [1:0] byp_mode;
	logic       latch_en;
	logic       sync_asgn;
	assign auth      = ctrl_q[`SGC_CTRL_AUTH_LSB +: 2];
	assign byp_mode  = ctrl_q[`SGC_CTRL_BYP_LSB +: 2];
	assign latch_en  = ctrl_q[`SGC_CTRL_LATCH_BIT];
	assign sync_asgn = ctrl_q[`SGC_CTRL_SYNCA_BIT];

	// Bus strobe
	logic wb_req;
	logic wb_wr;
	assign wb_req = wb_cyc_i && wb_stb_i && !wb_ack_o;
	assign wb_wr  = wb_req && wb_we_i && (wb_sel_i == 4'hf);

	// Register writes, full-word only
	always_ff @(posedge clk_i) begin
		if (rst_i) begin
			ctrl_q    <= 9'h000;
			asgn_q    <= '0;
			hold_q    <= HOLD_W'(`SGC_HOLD_RST);
			synclim_q <= `SGC_SYNC_RST;
			byptime_q <= `SGC_BYP_RST;
		end else if (wb_wr) begin
			case (wb_adr_i)
				`SGC_REG_CTRL:     ctrl_q    <= wb_dat_i[8:0];
				`SGC_REG_TRIPASGN: asgn_q    <= wb_dat_i[NSRC-1:0];
				`SGC_REG_HOLD:     hold_q    <= wb_dat_i[HOLD_W-1:0];
				`SGC_REG_SYNCLIM:  synclim_q <= wb_dat_i;
				`SGC_REG_BYPTIME:  byptime_q <= wb_dat_i;
				default: begin
				end
			endcase
		end
	end

	// Command register pulses, one cycle each
	always_ff @(posedge clk_i) begin
		if (rst_i) begin
			sw_close_q <= 1'b0;
			sw_open_q  <= 1'b0;
			sw_ack_q   <= 1'b0;
			sw_byp_q   <= 1'b0;
		end else begin
			sw_close_q <= wb_wr && wb_adr_i == `SGC_REG_CMD && wb_dat_i[`SGC_CMD_CLOSE_BIT];
			sw_open_q  <= wb_wr && wb_adr_i == `SGC_REG_CMD && wb_dat_i[`SGC_CMD_OPEN_BIT];
			sw_ack_q   <= wb_wr && wb_adr_i == `SGC_REG_CMD && wb_dat_i[`SGC_CMD_ACK_BIT];
			sw_byp_q   <= wb_wr && wb_adr_i == `SGC_REG_CMD && wb_dat_i[`SGC_CMD_BYP_BIT];
		end
	end

	// Read mux and one-cycle ack; unmapped reads zero
	logic        byp_act_q;
	logic        latched_q;
	always_ff @(posedge clk_i) begin
		if (rst_i) begin
			wb_ack_o <= 1'b0;
			wb_dat_o <= 32'h0000_0000;
		end else begin
			wb_ack_o <= wb_req;
			case (wb_adr_i)
				`SGC_REG_CTRL:     wb_dat_o <= {23'h000000, ctrl_q};
				`SGC_REG_TRIPASGN: wb_dat_o <= 32'(asgn_q);
				`SGC_REG_HOLD:     wb_dat_o <= 32'(hold_q);
				`SGC_REG_SYNCLIM:  wb_dat_o <= synclim_q;
				`SGC_REG_BYPTIME:  wb_dat_o <= byptime_q;
				`SGC_REG_STATUS:   wb_dat_o <= {24'h000000, override_flag_o, byp_act_q,
				                                latched_q, busy_o, trip_coil_o,
				                                close_coil_o, pos_o};
				default:           wb_dat_o <= 32'h0000_0000;
			endcase
		end
	end

	// ==========================================================
	// Position validation with override
	logic [1:0] pos_eff;
	assign pos_eff = ctrl_q[`SGC_CTRL_OVR_BIT] ? ctrl_q[`SGC_CTRL_OVRP_LSB +: 2]
	                                          : aux_pos_i;
	always_ff @(posedge clk_i) begin
		if (rst_i) begin
			pos_o           <= `SGC_POS_INDET;
			override_flag_o <= 1'b0;
		end else begin
			pos_o           <= pos_eff;
			override_flag_o <= ctrl_q[`SGC_CTRL_OVR_BIT];
		end
	end

	// ==========================================================
	// Trip manager
	logic        trip_any;
	logic        ack_any;
	logic [HOLD_W-1:0] hold_cnt_q;
	assign trip_any = |(prot_trip_i & asgn_q) && !prot_block_i;
	assign ack_any  = sw_ack_q || trip_ack_source_i;

	// Latch state
	always_ff @(posedge clk_i) begin
		if (rst_i) begin
			latched_q <= 1'b0;
		end else if (trip_any && latch_en) begin
			latched_q <= 1'b1;
		end else if (asgn_q == '0) begin
			latched_q <= 1'b0;
		end else if ((ack_any || !latch_en) && !(|(prot_trip_i & asgn_q))) begin
			// Ack or latch off only once every assigned source dropped
			latched_q <= 1'b0;
		end
	end

	// Minimum hold counter, reloaded while an assigned, unblocked source is active
	always_ff @(posedge clk_i) begin
		if (rst_i) begin
			hold_cnt_q <= '0;
		end else if (trip_any) begin
			hold_cnt_q <= hold_q;
		end else if (hold_cnt_q != '0) begin
			hold_cnt_q <= hold_cnt_q - 1'b1;
		end
	end

	// ==========================================================
	// Command sources and arbitration
	logic panel_close_q;
	logic ext_close_q;
	logic remote_ok;
	logic local_ok;
	logic req_open;
	logic req_close;
	logic byp_on;
	always_ff @(posedge clk_i) begin
		if (rst_i) begin
			panel_close_q <= 1'b0;
			ext_close_q   <= 1'b0;
		end else begin
			panel_close_q <= panel_close_i;
			ext_close_q   <= ext_close_source_i;
		end
	end
	assign local_ok  = auth == `SGC_AUTH_LOCAL || auth == `SGC_AUTH_BOTH;
	assign remote_ok = auth == `SGC_AUTH_REMOTE || auth == `SGC_AUTH_BOTH;
	assign byp_on    = byp_act_q || byp_mode == `SGC_BYP_PERM;
	// Open is level for external source
	assign req_open  = (local_ok && panel_open_i)
	                || (remote_ok && (remote_open_i || sw_open_q
	                    || ext_open_source_i || int_open_i));
	// Close: edge for panel and external
	assign req_close = (local_ok && panel_close_i && !panel_close_q)
	                || (remote_ok && (remote_close_i || sw_close_q || int_close_i
	                    || (ext_close_source_i && !ext_close_q)));
	logic open_ok;
	logic close_ok;
	assign open_ok  = req_open && (byp_on || ilock_open_i == 3'h0)
	               && pos_eff != `SGC_POS_OPEN;
	assign close_ok = req_close && !req_open
	               && (byp_on || ilock_close_i == 3'h0)
	               && pos_eff != `SGC_POS_CLOSED;

	// ==========================================================
	// Command sequencer
	sgc_pkg::sgc_state_t st_q;
	logic        dir_open_q;     // Direction of command in progress
	logic [31:0] tmr_q;          // Sync wait or pulse timer
	logic        sync_ok;
	logic        exec_evt;       // A switching command executes
	assign sync_ok  = !sync_asgn || sync_release_i;
	assign exec_evt = (st_q == sgc_pkg::SGC_IDLE && open_ok)
	               || (st_q == sgc_pkg::SGC_IDLE && close_ok && sync_ok)
	               || (st_q == sgc_pkg::SGC_SYNC && sync_ok);
	always_ff @(posedge clk_i) begin
		if (rst_i) begin
			st_q       <= sgc_pkg::SGC_IDLE;
			dir_open_q <= 1'b0;
			tmr_q      <= 32'h0000_0000;
		end else begin
			case (st_q)
				sgc_pkg::SGC_IDLE: begin
					if (open_ok) begin
						st_q       <= sgc_pkg::SGC_PULSE;
						dir_open_q <= 1'b1;
						tmr_q      <= 32'(PULSE_CYC);
					end else if (close_ok && sync_ok) begin
						st_q       <= sgc_pkg::SGC_PULSE;
						dir_open_q <= 1'b0;
						tmr_q      <= 32'(PULSE_CYC);
					end else if (close_ok) begin
						st_q       <= sgc_pkg::SGC_SYNC;
						dir_open_q <= 1'b0;
						tmr_q      <= synclim_q;
					end
				end
				sgc_pkg::SGC_SYNC: begin
					if (sync_ok) begin
						st_q  <= sgc_pkg::SGC_PULSE;
						tmr_q <= 32'(PULSE_CYC);
					end else if (tmr_q <= 32'h0000_0001) begin
						st_q  <= sgc_pkg::SGC_IDLE;
					end else begin
						tmr_q <= tmr_q - 32'h0000_0001;
					end
				end
				sgc_pkg::SGC_PULSE: begin
					if (tmr_q <= 32'h0000_0001) begin
						st_q <= sgc_pkg::SGC_IDLE;
					end else begin
						tmr_q <= tmr_q - 32'h0000_0001;
					end
				end
				default: st_q <= sgc_pkg::SGC_IDLE;
			endcase
		end
	end

	// ==========================================================
	// Interlock bypass timing
	logic [31:0] byp_cnt_q;
	always_ff @(posedge clk_i) begin
		if (rst_i) begin
			byp_act_q <= 1'b0;
			byp_cnt_q <= 32'h0000_0000;
		end else if ((sw_byp_q || bypass_sig_i) && (byp_mode == `SGC_BYP_SINGLE
		             || byp_mode == `SGC_BYP_TIMED)) begin
			byp_act_q <= 1'b1;
			byp_cnt_q <= byptime_q;
		end else if (byp_act_q) begin
			if (byp_cnt_q <= 32'h0000_0001 || byp_mode == `SGC_BYP_OFF
			    || byp_mode == `SGC_BYP_PERM) begin
				byp_act_q <= 1'b0;
			end else if (byp_mode == `SGC_BYP_SINGLE && exec_evt) begin
				byp_act_q <= 1'b0;
			end else begin
				byp_cnt_q <= byp_cnt_q - 32'h0000_0001;
			end
		end
	end

	// ==========================================================
	// Coil outputs
	always_ff @(posedge clk_i) begin
		if (rst_i) begin
			close_coil_o <= 1'b0;
			trip_coil_o  <= 1'b0;
			busy_o       <= 1'b0;
		end else begin
			close_coil_o <= st_q == sgc_pkg::SGC_PULSE && !dir_open_q
			             && !auto_reclose_unit_i;
			// Reclose pulse bypasses interlocks and authority
			if (auto_reclose_unit_i && !trip_coil_o && pos_eff != `SGC_POS_CLOSED) begin
				close_coil_o <= 1'b1;
			end
			trip_coil_o  <= trip_any || latched_q || hold_cnt_q != '0
			             || (st_q == sgc_pkg::SGC_PULSE && dir_open_q);
			busy_o       <= st_q != sgc_pkg::SGC_IDLE;
		end
	end

	// ==========================================================
	// Assertions
	a_trip_follows_src: assert property (@(posedge clk_i) disable iff (rst_i)
		trip_any |=> trip_coil_o) else $error("trip not issued");
	a_unasgn_no_trip: assert property (@(posedge clk_i) disable iff (rst_i)
		(asgn_q == '0 && st_q == sgc_pkg::SGC_IDLE && !latched_q && hold_cnt_q == '0
		 && $past(st_q) == sgc_pkg::SGC_IDLE) |=> !trip_coil_o)
		else $error("unassigned trip acted");
	a_trip_hold_min: assert property (@(posedge clk_i) disable iff (rst_i)
		(trip_any && hold_q > 1) |=> (hold_cnt_q == hold_q)) else $error("hold not loaded");
	a_latch_holds: assert property (@(posedge clk_i) disable iff (rst_i)
		(latched_q && latch_en && !ack_any && asgn_q != '0) |=> latched_q)
		else $error("latch lost");
	a_latch_no_early: assert property (@(posedge clk_i) disable iff (rst_i)
		(latched_q && latch_en && |(prot_trip_i & asgn_q)) |=> latched_q)
		else $error("latch cleared with source");
	a_one_at_time: assert property (@(posedge clk_i) disable iff (rst_i)
		(st_q == sgc_pkg::SGC_PULSE && tmr_q > 1) |=> st_q == sgc_pkg::SGC_PULSE)
		else $error("command overlapped");
	a_open_priority: assert property (@(posedge clk_i) disable iff (rst_i)
		(st_q == sgc_pkg::SGC_IDLE && open_ok) |=> dir_open_q) else $error("close beat open");
	a_auth_none: assert property (@(posedge clk_i) disable iff (rst_i)
		(auth == `SGC_AUTH_NONE) |-> !(open_ok || close_ok)) else $error("authority none");
	a_same_pos_drop: assert property (@(posedge clk_i) disable iff (rst_i)
		(pos_eff == `SGC_POS_CLOSED) |-> !close_ok) else $error("close to closed");
	a_sync_timeout: assert property (@(posedge clk_i) disable iff (rst_i)
		(st_q == sgc_pkg::SGC_SYNC && !sync_ok && tmr_q <= 1) |=> st_q == sgc_pkg::SGC_IDLE)
		else $error("sync timeout missed");

endmodule

`default_nettype wire

/* inc/sgc_consts.svh */
// Constants for the switchgear command control block.
// Assumes a 10 MHz system clock; included by bare name.
`ifndef SGC_CONSTS_SVH
`define SGC_CONSTS_SVH

// Clock rate in Hz
`define SGC_CLK_HZ          10000000
// Validated position codes
`define SGC_POS_INDET       2'h0
`define SGC_POS_OPEN        2'h1
`define SGC_POS_CLOSED      2'h2
`define SGC_POS_DISTURB     2'h3
// Switching authority codes
`define SGC_AUTH_NONE       2'h0
`define SGC_AUTH_LOCAL      2'h1
`define SGC_AUTH_REMOTE     2'h2
`define SGC_AUTH_BOTH       2'h3
// Interlock bypass modes
`define SGC_BYP_OFF         2'h0
`define SGC_BYP_SINGLE      2'h1
`define SGC_BYP_PERM        2'h2
`define SGC_BYP_TIMED       2'h3
// Register byte offsets
`define SGC_REG_CTRL        8'h00
`define SGC_REG_TRIPASGN    8'h04
`define SGC_REG_HOLD        8'h08
`define SGC_REG_SYNCLIM     8'h0c
`define SGC_REG_BYPTIME     8'h10
`define SGC_REG_CMD         8'h14
`define SGC_REG_STATUS      8'h18
// Control register fields
`define SGC_CTRL_AUTH_LSB   0
`define SGC_CTRL_BYP_LSB    2
`define SGC_CTRL_LATCH_BIT  4
`define SGC_CTRL_SYNCA_BIT  5
`define SGC_CTRL_OVR_BIT    6
`define SGC_CTRL_OVRP_LSB   7
// Command register bits (write pulses)
`define SGC_CMD_CLOSE_BIT   0
`define SGC_CMD_OPEN_BIT    1
`define SGC_CMD_ACK_BIT     2
`define SGC_CMD_BYP_BIT     3
// Reset values of timing registers, in cycles
`define SGC_HOLD_RST        32'h0000_0fa0
`define SGC_SYNC_RST        32'h0000_4e20
`define SGC_BYP_RST         32'h0000_c350

`endif

/* inc/sgc_pkg.sv */
// Types for the switchgear command control block.
// Assumes nothing of its surroundings.
`default_nettype none
package sgc_pkg;
	// Command sequencer states
	typedef enum logic [1:0] {
		SGC_IDLE  = 2'b00,
		SGC_SYNC  = 2'b01,
		SGC_PULSE = 2'b10
	} sgc_state_t;
endpackage
`default_nettype wire

/* verif/sgc_breaker_model.sv */
// Breaker model: coil pulses in, validated position code out.
// Assumes the command block's clock and synchronous reset.
`timescale 1ns/10ps
`include "sgc_consts.svh"
`default_nettype none
module sgc_breaker_model #(
	parameter int MOVE = 2 // Travel time in cycles
) (
	// Clock and reset
	input  wire logic       clk_i,
	input  wire logic       rst_i,
	// Coils
	input  wire logic       close_coil_i,
	input  wire logic       trip_coil_i,
	// Position
	output logic      [1:0] aux_pos_o
);
	// ==========
	// Travel
	int         cnt_q; // Cycles of travel left
	logic [1:0] tgt_q; // End position of travel
	// Coil starts travel, position indeterminate meanwhile
	always_ff @(posedge clk_i) begin
		if (rst_i) begin
			aux_pos_o <= `SGC_POS_OPEN;
			cnt_q <= 0;
			tgt_q <= `SGC_POS_OPEN;
		end else if (trip_coil_i) begin
			aux_pos_o <= `SGC_POS_INDET;
			tgt_q <= `SGC_POS_OPEN;
			cnt_q <= MOVE;
		end else if (close_coil_i) begin
			aux_pos_o <= `SGC_POS_INDET;
			tgt_q <= `SGC_POS_CLOSED;
			cnt_q <= MOVE;
		end else if (cnt_q == 1) begin
			aux_pos_o <= tgt_q;
			cnt_q <= 0;
		end else if (cnt_q > 1) begin
			cnt_q <= cnt_q - 1;
		end
	end
endmodule
`default_nettype wire

/* verif/sgc_top_tb.sv */
// Self-checking bench for the command block with a breaker model.
// Assumes a 10 MHz clock and PULSE_CYC set to 4.
`timescale 1ns/10ps
`include "sgc_consts.svh"
`default_nettype none
module sgc_top_tb;
	// ==========
	// Signals
	logic        clk_i = 1'b0;
	logic        rst_i = 1'b1;
	logic        wb_cyc_i = 1'b0, wb_stb_i = 1'b0, wb_we_i = 1'b0;
	logic [7:0]  wb_adr_i = 8'h00;
	logic [3:0]  wb_sel_i = 4'h0;
	logic [31:0] wb_dat_i = 32'h0, wb_dat_o;
	logic        wb_ack_o;
	logic        panel_close_i = 0, panel_open_i = 0, remote_close_i = 0, remote_open_i = 0;
	logic        ext_close_source_i = 0, ext_open_source_i = 0, int_close_i = 0, int_open_i = 0;
	logic        auto_reclose_unit_i = 0, prot_block_i = 0, trip_ack_source_i = 0;
	logic        sync_release_i = 0, bypass_sig_i = 0;
	logic [7:0]  prot_trip_i = 8'h00;
	logic [2:0]  ilock_close_i = 3'h0, ilock_open_i = 3'h0;
	logic [1:0]  aux_pos_i, pos_o;
	logic        close_coil_o, trip_coil_o, override_flag_o, busy_o;
	int          n_errors = 0, n_compared = 0, nc, nt;
	// Clock, 100 ns period
	always #50 clk_i = ~clk_i;
	// ==========
	// Instances
	sgc_top #(.NSRC(8), .PULSE_CYC(4), .HOLD_W(32)) u_sgc_top (.clk_i, .rst_i,
		.wb_cyc_i, .wb_stb_i, .wb_we_i, .wb_adr_i, .wb_sel_i, .wb_dat_i, .wb_dat_o,
		.wb_ack_o, .panel_close_i, .panel_open_i, .remote_close_i, .remote_open_i,
		.ext_close_source_i, .ext_open_source_i, .int_close_i, .int_open_i,
		.auto_reclose_unit_i, .prot_trip_i, .prot_block_i, .trip_ack_source_i,
		.ilock_close_i, .ilock_open_i, .sync_release_i, .bypass_sig_i, .aux_pos_i,
		.close_coil_o, .trip_coil_o, .pos_o, .override_flag_o, .busy_o);
	sgc_breaker_model u_sgc_breaker_model (.clk_i(clk_i), .rst_i(rst_i),
		.close_coil_i(close_coil_o), .trip_coil_i(trip_coil_o), .aux_pos_o(aux_pos_i));
	// ==========
	// Shared tasks
	task automatic complete_run();
		$display("Compared %0d, mismatches %0d", n_compared, n_errors);
		if (n_errors == 0 && n_compared > 0) begin
			$display("[ PASS ]");
		end else begin
			$display("[ FAIL ]");
		end
		$finish;
	endtask
	// Count one comparison, report a mismatch
	task automatic chk(input logic ok, input string m);
		n_compared++;
		if (ok !== 1'b1) begin
			n_errors++;
			$display("[FAIL] %0t %s", $time, m);
		end
	endtask
	// One classic Wishbone cycle, held until ack
	task automatic wb_cycle(input logic w, input logic [7:0] a, input logic [31:0] d,
		output logic [31:0] q);
		int i;
		@(posedge clk_i);
		wb_cyc_i <= 1'b1;
		wb_stb_i <= 1'b1;
		wb_we_i <= w;
		wb_adr_i <= a;
		wb_sel_i <= 4'hf;
		wb_dat_i <= d;
		for (i = 0; i < 20; i++) begin
			@(posedge clk_i);
			if (wb_ack_o === 1'b1) break;
		end
		q = wb_dat_o;
		wb_cyc_i <= 1'b0;
		wb_stb_i <= 1'b0;
		wb_we_i <= 1'b0;
		if (i == 20) begin
			chk(1'b0, "bus timeout");
			complete_run();
		end
	endtask
	task automatic wr(input logic [7:0] a, input logic [31:0] d);
		logic [31:0] q;
		wb_cycle(1'b1, a, d, q);
	endtask
	task automatic rd(input logic [7:0] a, input logic [31:0] e);
		logic [31:0] q;
		wb_cycle(1'b0, a, 32'h0, q);
		chk(q === e, "read data");
	endtask
	// Run n cycles counting coil cycles; drop commands after hold, release at rel
	task automatic watch(input int n, input int hold, input int rel);
		nc = 0;
		nt = 0;
		for (int i = 0; i < n; i++) begin
			@(posedge clk_i);
			if (i == rel) sync_release_i <= 1'b1;
			if (i == hold) begin
				{panel_close_i, panel_open_i, remote_close_i, remote_open_i} <= 4'h0;
				{ext_close_source_i, ext_open_source_i, int_close_i, int_open_i} <= 4'h0;
				{auto_reclose_unit_i, trip_ack_source_i, sync_release_i} <= 3'h0;
				prot_trip_i <= 8'h00;
			end
			@(negedge clk_i);
			nc += (close_coil_o === 1'b1);
			nt += (trip_coil_o === 1'b1);
		end
		// Return on a rising edge so callers drive there
		@(posedge clk_i);
	endtask
	// ==========
	// Scenarios
	task automatic t_regs();
		rd(`SGC_REG_HOLD, `SGC_HOLD_RST);
		rd(`SGC_REG_SYNCLIM, `SGC_SYNC_RST);
		rd(`SGC_REG_BYPTIME, `SGC_BYP_RST);
		rd(8'h20, 32'h0);
		$display("t_regs done");
	endtask
	task automatic t_close();
		wr(`SGC_REG_CTRL, 32'h3);
		panel_close_i <= 1'b1;
		watch(20, 10, -1);
		chk(nc == 4, "one pulse per press");
		panel_close_i <= 1'b1;
		watch(12, 1, -1);
		chk(nc == 0, "close when closed");
		$display("t_close done");
	endtask
	task automatic t_ilock();
		ilock_open_i <= 3'h4;
		int_open_i <= 1'b1;
		watch(12, 2, -1);
		chk(nt == 0, "open interlock");
		wr(`SGC_REG_CTRL, 32'hb);
		remote_open_i <= 1'b1;
		watch(12, 2, -1);
		chk(nt == 4, "permanent bypass");
		wr(`SGC_REG_CTRL, 32'h3);
		ilock_close_i <= 3'h7;
		auto_reclose_unit_i <= 1'b1;
		watch(12, 1, -1);
		chk(nc > 0, "reclose past interlock");
		ilock_open_i <= 3'h0;
		ilock_close_i <= 3'h0;
		$display("t_ilock done");
	endtask
	task automatic t_ext();
		ext_open_source_i <= 1'b1;
		watch(12, 2, -1);
		chk(nt == 4, "external open");
		ext_close_source_i <= 1'b1;
		watch(20, 20, -1);
		chk(nc == 4, "external close edge");
		$display("t_ext done");
	endtask
	task automatic t_auth();
		wr(`SGC_REG_CTRL, 32'h1);
		remote_open_i <= 1'b1;
		watch(12, 1, -1);
		chk(nt == 0, "remote under local");
		wr(`SGC_REG_CTRL, 32'h0);
		panel_open_i <= 1'b1;
		watch(12, 1, -1);
		chk(nt == 0, "panel under none");
		wr(`SGC_REG_CTRL, 32'h1);
		panel_open_i <= 1'b1;
		watch(12, 1, -1);
		chk(nt == 4, "panel under local");
		$display("t_auth done");
	endtask
	task automatic t_sync();
		wr(`SGC_REG_CTRL, 32'h23);
		wr(`SGC_REG_SYNCLIM, 32'ha);
		remote_close_i <= 1'b1;
		watch(25, 1, -1);
		chk(nc == 0, "close without sync");
		chk(busy_o === 1'b0, "slot freed");
		remote_close_i <= 1'b1;
		watch(20, 1, 3);
		chk(nc == 4, "close on sync");
		$display("t_sync done");
	endtask
	task automatic t_trip();
		wr(`SGC_REG_CTRL, 32'h0);
		wr(`SGC_REG_TRIPASGN, 32'h1);
		wr(`SGC_REG_HOLD, 32'h5);
		prot_trip_i <= 8'h02;
		watch(10, 3, -1);
		chk(nt == 0, "unassigned source");
		prot_trip_i <= 8'h01;
		prot_block_i <= 1'b1;
		watch(10, 3, -1);
		chk(nt == 0, "blocked trip");
		prot_block_i <= 1'b0;
		prot_trip_i <= 8'h01;
		watch(20, 1, -1);
		chk(nt >= 5 && nt < 15, "trip hold");
		$display("t_trip done");
	endtask
	task automatic t_latch();
		wr(`SGC_REG_CTRL, 32'h13);
		prot_trip_i <= 8'h01;
		watch(20, 2, -1);
		chk(trip_coil_o === 1'b1, "latched trip");
		prot_trip_i <= 8'h01;
		trip_ack_source_i <= 1'b1;
		watch(10, 99, -1);
		chk(trip_coil_o === 1'b1, "ack with source up");
		watch(4, 0, -1);
		trip_ack_source_i <= 1'b1;
		watch(15, 1, -1);
		chk(trip_coil_o === 1'b0, "ack clears");
		prot_trip_i <= 8'h01;
		watch(4, 2, -1);
		wr(`SGC_REG_CMD, 32'h4);
		watch(10, 0, -1);
		chk(trip_coil_o === 1'b0, "software ack");
		prot_trip_i <= 8'h01;
		watch(4, 2, -1);
		wr(`SGC_REG_TRIPASGN, 32'h0);
		watch(10, 0, -1);
		chk(trip_coil_o === 1'b0, "nothing assigned");
		$display("t_latch done");
	endtask
	task automatic t_prio();
		wr(`SGC_REG_CTRL, 32'h43);
		watch(3, 9, -1);
		chk(pos_o === `SGC_POS_INDET && override_flag_o === 1'b1, "override");
		remote_open_i <= 1'b1;
		int_close_i <= 1'b1;
		watch(15, 1, -1);
		chk(nt == 4 && nc == 0, "open wins");
		$display("t_prio done");
	endtask
	// Bypass modes, bypass signal and software commands
	task automatic t_byp();
		wr(`SGC_REG_CTRL, 32'h7);
		ilock_close_i <= 3'h7;
		ilock_open_i <= 3'h7;
		wr(`SGC_REG_CMD, 32'h8);
		remote_close_i <= 1'b1;
		watch(20, 1, -1);
		chk(nc == 4, "single bypass close");
		remote_open_i <= 1'b1;
		watch(12, 1, -1);
		chk(nt == 0, "single bypass used up");
		wr(`SGC_REG_CTRL, 32'hf);
		wr(`SGC_REG_BYPTIME, 32'h5);
		bypass_sig_i <= 1'b1;
		watch(2, 9, -1);
		bypass_sig_i <= 1'b0;
		remote_open_i <= 1'b1;
		watch(12, 1, -1);
		chk(nt == 4, "bypass by signal");
		remote_close_i <= 1'b1;
		watch(12, 1, -1);
		chk(nc == 0, "timed bypass expired");
		ilock_close_i <= 3'h0;
		ilock_open_i <= 3'h0;
		wr(`SGC_REG_CMD, 32'h1);
		watch(12, 12, -1);
		chk(nc == 4, "software close");
		$display("t_byp done");
	endtask
	// ==========
	// Main sequence
	initial begin
		repeat (2) @(posedge clk_i);
		rst_i <= 1'b0;
		t_regs();
		t_close();
		t_ilock();
		t_ext();
		t_auth();
		t_sync();
		t_trip();
		t_latch();
		t_prio();
		t_byp();
		complete_run();
	end
endmodule
`default_nettype wire
